// file: pkg/fspc_defines.svh
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH
// Register byte offsets on the APB.
`define FSPC_OFF_ADDR_LOW 8'h00
`define FSPC_OFF_ADDR_HIGH 8'h04
`define FSPC_OFF_DATA_LOW 8'h08
`define FSPC_OFF_DATA_HIGH 8'h0C
`define FSPC_OFF_CONTROL 8'h10
`define FSPC_OFF_UNLOCK 8'h14
`define FSPC_OFF_CONFIG 8'h18
// Control register bit positions.
`define FSPC_BIT_RD 0
`define FSPC_BIT_WR 1
`define FSPC_BIT_WRITE_PERMIT_BIT 2
`define FSPC_BIT_WRITE_ABORT_FLAG 3
`define FSPC_BIT_FREE 4
`define FSPC_BIT_LWLO 5
`define FSPC_BIT_CONFIG_SPACE_SELECT 6
// Unlock pattern bytes.
`define FSPC_KEY_FIRST 8'h55
`define FSPC_KEY_SECOND 8'hAA
// Reset values.
`define FSPC_LATCH_RESET 14'h3FFF
`define FSPC_CTRL_RESET 1'b0
// Write protect boundaries, word addresses.
`define FSPC_WRT_QUARTER 15'h2000
`define FSPC_WRT_HALF 15'h4000
// Timing.
`define FSPC_CLK_NS 10
`define FSPC_PROG_TIME_NS 2000000
`define FSPC_TIMER_W 18
`endif

// file: pkg/fspc_pkg.sv
package fspc_pkg;
	typedef enum logic [2:0] {
		FSPC_IDLE = 3'b000,
		FSPC_RD_ACC = 3'b001,
		FSPC_RD_DATA = 3'b010,
		FSPC_WR_SU1 = 3'b011,
		FSPC_WR_SU2 = 3'b100,
		FSPC_ERASE = 3'b101,
		FSPC_PROG = 3'b110
	} fspc_state_e;
	// Request to the flash array.
	typedef struct packed {
		logic rd;
		logic erase;
		logic prog;
		logic config_space_select;
		logic [14:0] addr;
	} fspc_flreq_s;
	typedef logic [13:0] fspc_word_t;
endpackage

// file: hdl/fspc_unlock.sv
`timescale 1ns/100ps
`include "fspc_defines.svh"
module fspc_unlock import fspc_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Unlock register writes
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	// Start attempt, consumes the arming
	input wire logic consume,
	output logic armed
);
	logic got_first_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			got_first_reg <= 1'b0;
			armed <= 1'b0;
		end else if (ce) begin
			if (key_wr) begin
				// Only the exact two-byte order arms; anything else disarms.
				got_first_reg <= (key_data == `FSPC_KEY_FIRST);
				armed <= got_first_reg && (key_data == `FSPC_KEY_SECOND);
			end else if (consume) begin
				got_first_reg <= 1'b0;
				armed <= 1'b0;
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_unlock_order: assert property ($rose(armed) |-> $past(key_wr) && $past(key_data) == 8'hAA)
		else $error("unlock armed without second key byte");
endmodule

// file: hdl/fspc_latches.sv
`timescale 1ns/100ps
`include "fspc_defines.svh"
module fspc_latches import fspc_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// Load and clear
	input wire logic load,
	input wire logic [3:0] idx,
	input wire logic [13:0] wdata,
	input wire logic clear_all,
	// Whole row
	output logic [223:0] row
);
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : gen_latch
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					row[g*14 +: 14] <= `FSPC_LATCH_RESET;
				end else if (ce) begin
					if (clear_all) begin
						row[g*14 +: 14] <= `FSPC_LATCH_RESET;
					end else if (load && idx == 4'(g)) begin
						row[g*14 +: 14] <= wdata;
					end
				end
			end
		end
	endgenerate
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_latch_load_word: assert property (ce && load && !clear_all |=> row[$past(idx)*14 +: 14] == $past(wdata))
		else $error("write latch did not take the loaded word");
endmodule

// file: hdl/fspc_top.sv
`timescale 1ns/100ps
`include "fspc_defines.svh"
// What this block does
// - Data pair 14 bits, address pair 15.
// - Address pair spans 32K words, high/low.
// - Software only sets start bits, never clears.
// - Hardware clears start bits when done.
// - Write or erase needs permit; reset zero.
// - Reset during write sets abort flag.
// - Unlock register reads as zero.
// - Latch load and write need unlock.
// - Internal timer times write and erase.
// - Code protect blocks external read/write.
// - Only external bulk erase lifts protection.
// - Write protect field blocks self-write regions.
// - Erase works on whole 16-word rows.
// - Sixteen 14-bit latches, loaded sequentially.
// - Unprogrammed words writable without erase.
// - Unlock is 55h, AAh, then start.
// - Read uses second cycle, data next.
// - Erase stalls CPU, resumes third instruction.
// - Completed write resets latches to 3FFF.
module fspc_top import fspc_pkg::*; #(
	parameter int unsigned PROG_CYC = (`FSPC_PROG_TIME_NS + `FSPC_CLK_NS - 1) / `FSPC_CLK_NS
) (
	// Clock, resets and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Configuration word
	input wire logic cfg_code_protect_n,
	input wire logic [1:0] cfg_write_protect,
	// External programmer
	input wire logic ext_rd_req,
	input wire logic ext_wr_req,
	input wire logic ext_bulk_req,
	output logic ext_rd_ok,
	output logic ext_wr_ok,
	output logic ext_bulk,
	// Flash array
	output fspc_flreq_s fl_req,
	output logic [223:0] fl_row_data,
	input wire logic [13:0] fl_rdata,
	// Processor pipeline
	output logic cpu_stall,
	output logic cpu_ignore
);
	////////////////////////////////////////////////////////////////////////////////
	fspc_state_e state_reg;
	logic [`FSPC_TIMER_W-1:0] timer_reg;
	logic [7:0] addr_low_reg;
	logic [6:0] addr_high_reg;
	logic [7:0] data_low_reg;
	logic [5:0] data_high_reg;
	logic rd_reg, wr_reg, write_permit_bit_reg, free_reg, lwlo_reg, config_space_select_reg;
	logic write_abort_flag_reg, wip_reg;
	logic acc, wr_acc, unmapped, wr_ctrl, armed, prot, go_rd, go_wr, timer_end;
	logic sel_al, sel_ah, sel_dl, sel_dh, sel_ctl, sel_unl, sel_cfg;
	logic [14:0] addr;
	logic [31:0] rd_mux;
	logic latch_load, latch_clear;

	assign sel_al = paddr == `FSPC_OFF_ADDR_LOW;
	assign sel_ah = paddr == `FSPC_OFF_ADDR_HIGH;
	assign sel_dl = paddr == `FSPC_OFF_DATA_LOW;
	assign sel_dh = paddr == `FSPC_OFF_DATA_HIGH;
	assign sel_ctl = paddr == `FSPC_OFF_CONTROL;
	assign sel_unl = paddr == `FSPC_OFF_UNLOCK;
	assign sel_cfg = paddr == `FSPC_OFF_CONFIG;
	assign unmapped = !(sel_al || sel_ah || sel_dl || sel_dh || sel_ctl || sel_unl || sel_cfg);
	assign acc = psel && penable;
	assign wr_acc = acc && pwrite && !unmapped;
	assign wr_ctrl = wr_acc && sel_ctl;
	// Zero wait states: every access completes in its first access cycle.
	assign pready = 1'b1;
	assign pslverr = acc && unmapped;
	assign addr = {addr_high_reg, addr_low_reg};

	////////////////////////////////////////////////////////////////////////////////
	// Write protection only guards self-write; config space stays open.
	always_comb begin
		unique case (cfg_write_protect)
			2'b11: prot = 1'b0;
			2'b10: prot = addr < `FSPC_WRT_QUARTER;
			2'b01: prot = addr < `FSPC_WRT_HALF;
			2'b00: prot = 1'b1;
		endcase
		prot = prot && !config_space_select_reg;
	end

	// A write start is taken only when permitted, unlocked and unprotected.
	assign go_wr = ce && wr_ctrl && pwdata[`FSPC_BIT_WR] && state_reg == FSPC_IDLE
		&& armed && write_permit_bit_reg && !prot;
	assign go_rd = ce && wr_ctrl && pwdata[`FSPC_BIT_RD] && state_reg == FSPC_IDLE && !go_wr;
	assign timer_end = timer_reg == `FSPC_TIMER_W'(PROG_CYC - 1);

	fspc_unlock u_unlock (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.key_wr(wr_acc && sel_unl),
		.key_data(pwdata[7:0]),
		.consume(wr_ctrl && pwdata[`FSPC_BIT_WR]),
		.armed(armed)
	);

	fspc_latches u_latches (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.load(latch_load),
		.idx(addr_low_reg[3:0]),
		.wdata({data_high_reg, data_low_reg}),
		.clear_all(latch_clear),
		.row(fl_row_data)
	);

	// Latches load at the end of setup unless the start is an erase.
	assign latch_load = state_reg == FSPC_WR_SU2 && !free_reg;
	assign latch_clear = state_reg == FSPC_PROG && timer_end;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= FSPC_IDLE;
			timer_reg <= '0;
			fl_req <= '0;
		end else if (ce) begin
			unique case (state_reg)
				FSPC_IDLE: begin
					fl_req.config_space_select <= config_space_select_reg;
					fl_req.addr <= addr;
					if (go_wr) begin
						state_reg <= FSPC_WR_SU1;
					end else if (go_rd) begin
						state_reg <= FSPC_RD_ACC;
						fl_req.rd <= 1'b1;
					end
				end
				FSPC_RD_ACC: begin
					fl_req.rd <= 1'b0;
					state_reg <= FSPC_RD_DATA;
				end
				FSPC_RD_DATA: state_reg <= FSPC_IDLE;
				FSPC_WR_SU1: state_reg <= FSPC_WR_SU2;
				FSPC_WR_SU2: begin
					timer_reg <= '0;
					if (free_reg) begin
						// Row address only; the low four bits are ignored.
						state_reg <= FSPC_ERASE;
						fl_req.erase <= 1'b1;
					end else if (lwlo_reg) begin
						state_reg <= FSPC_IDLE;
					end else begin
						// Untouched latches hold all ones, which leaves those words as they are.
						state_reg <= FSPC_PROG;
						fl_req.prog <= 1'b1;
					end
				end
				FSPC_ERASE, FSPC_PROG: begin
					timer_reg <= timer_reg + `FSPC_TIMER_W'(1);
					if (timer_end) begin
						state_reg <= FSPC_IDLE;
						fl_req.erase <= 1'b0;
						fl_req.prog <= 1'b0;
					end
				end
				default: state_reg <= FSPC_IDLE;
			endcase
		end
	end

	// The processor sees two forced cycles, then the timed stall.
	assign cpu_stall = state_reg inside {FSPC_WR_SU1, FSPC_WR_SU2, FSPC_ERASE, FSPC_PROG};
	assign cpu_ignore = state_reg == FSPC_RD_ACC;

	////////////////////////////////////////////////////////////////////////////////
	// Start bits: software can only set them, so a write cannot be aborted.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_reg <= `FSPC_CTRL_RESET;
			wr_reg <= `FSPC_CTRL_RESET;
		end else if (ce) begin
			if (go_rd) begin
				rd_reg <= 1'b1;
			end else if (state_reg == FSPC_RD_DATA) begin
				rd_reg <= 1'b0;
			end
			if (go_wr) begin
				wr_reg <= 1'b1;
			end else if ((state_reg == FSPC_WR_SU2 && lwlo_reg && !free_reg) || timer_end) begin
				wr_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_permit_bit_reg <= `FSPC_CTRL_RESET;
			free_reg <= `FSPC_CTRL_RESET;
			lwlo_reg <= `FSPC_CTRL_RESET;
			config_space_select_reg <= `FSPC_CTRL_RESET;
		end else if (ce && wr_ctrl) begin
			write_permit_bit_reg <= pwdata[`FSPC_BIT_WRITE_PERMIT_BIT];
			free_reg <= pwdata[`FSPC_BIT_FREE];
			lwlo_reg <= pwdata[`FSPC_BIT_LWLO];
			config_space_select_reg <= pwdata[`FSPC_BIT_CONFIG_SPACE_SELECT];
		end
	end

	// These two survive every reset but power-on, so a broken write is seen afterwards.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			wip_reg <= 1'b0;
			write_abort_flag_reg <= 1'b0;
		end else if (ce) begin
			if (state_reg == FSPC_WR_SU2 && !(lwlo_reg && !free_reg)) begin
				wip_reg <= 1'b1;
			end else if (timer_end || state_reg == FSPC_IDLE) begin
				wip_reg <= 1'b0;
			end
			// Idle with a write still marked means reset cut it short; set beats clear.
			if (wip_reg && state_reg == FSPC_IDLE) begin
				write_abort_flag_reg <= 1'b1;
			end else if (wr_ctrl && !pwdata[`FSPC_BIT_WRITE_ABORT_FLAG]) begin
				write_abort_flag_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address and data pairs; a finished read overwrites the data pair.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_low_reg <= 8'h00;
			addr_high_reg <= 7'h00;
		end else if (ce) begin
			if (wr_acc && sel_al) begin
				addr_low_reg <= pwdata[7:0];
			end
			if (wr_acc && sel_ah) begin
				addr_high_reg <= pwdata[6:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_low_reg <= 8'h00;
			data_high_reg <= 6'h00;
		end else if (ce) begin
			if (state_reg == FSPC_RD_DATA) begin
				{data_high_reg, data_low_reg} <= fl_rdata;
			end else begin
				if (wr_acc && sel_dl) begin
					data_low_reg <= pwdata[7:0];
				end
				if (wr_acc && sel_dh) begin
					data_high_reg <= pwdata[5:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data is captured in the setup cycle, so it stands in the access cycle.
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_al) rd_mux[7:0] = addr_low_reg;
		if (sel_ah) rd_mux[6:0] = addr_high_reg;
		if (sel_dl) rd_mux[7:0] = data_low_reg;
		if (sel_dh) rd_mux[5:0] = data_high_reg;
		if (sel_ctl) rd_mux[6:0] = {config_space_select_reg, lwlo_reg, free_reg, write_abort_flag_reg, write_permit_bit_reg, wr_reg, rd_reg};
		if (sel_cfg) rd_mux[2:0] = {cfg_write_protect, cfg_code_protect_n};
		// The unlock register is write-only and falls through as zero.
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// External programmer gate. Bulk erase is never blocked, since it is the only
	// way back from code protection; the array clears the configuration word itself.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_rd_ok <= 1'b0;
			ext_wr_ok <= 1'b0;
			ext_bulk <= 1'b0;
		end else if (ce) begin
			ext_rd_ok <= ext_rd_req && cfg_code_protect_n;
			ext_wr_ok <= ext_wr_req && cfg_code_protect_n;
			ext_bulk <= ext_bulk_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);

	sequence s_setup;
		state_reg == FSPC_WR_SU1 && cpu_stall ##1 state_reg == FSPC_WR_SU2 && cpu_stall;
	endsequence

	sequence s_read;
		fl_req.rd && cpu_ignore && rd_reg ##1 !fl_req.rd && rd_reg ##1 !rd_reg;
	endsequence

	a_read_slot: assert property (go_rd |=> s_read)
		else $error("read did not use the second cycle");
	a_write_unlock: assert property ($rose(wr_reg) |-> $past(armed) && $past(write_permit_bit_reg))
		else $error("write started without unlock and permit");
	a_stall_setup: assert property (go_wr |=> s_setup)
		else $error("write start not followed by two stall cycles");
	a_timed_length: assert property ($fell(fl_req.erase) || $fell(fl_req.prog) |-> $past(timer_reg) == 18'(PROG_CYC - 1))
		else $error("array operation not timed by the internal timer");
	a_start_clear: assert property ($fell(wr_reg) |-> $past(state_reg) inside {FSPC_WR_SU2, FSPC_ERASE, FSPC_PROG})
		else $error("write start bit cleared outside completion");
	a_latch_reset: assert property ($fell(fl_req.prog) |-> fl_row_data == {16{14'h3FFF}})
		else $error("latches not reset after program");
	a_unlock_zero: assert property (acc && !pwrite && sel_unl |-> prdata == 32'h0000_0000)
		else $error("unlock register read not zero");
	a_wprot_block: assert property (wr_ctrl && pwdata[1] && prot && state_reg == FSPC_IDLE |=> !wr_reg)
		else $error("protected region accepted a write start");
	a_code_protect: assert property (ext_rd_ok || ext_wr_ok |-> $past(cfg_code_protect_n))
		else $error("external access granted under code protection");
	a_abort_flag: assert property (@(posedge pclk) disable iff (!por_n || !ce)
		wip_reg && state_reg == FSPC_IDLE |=> write_abort_flag_reg)
		else $error("interrupted write did not raise the abort flag");
endmodule

// file: test/fspc_flash_model.sv
`timescale 1ns/100ps
module fspc_flash_model import fspc_pkg::*; (
	// Clock
	input wire logic pclk,
	// Array side
	input wire fspc_flreq_s fl_req,
	input wire logic [223:0] fl_row_data,
	output logic [13:0] fl_rdata
);
	fspc_word_t mem[int];
	fspc_word_t last_q = 14'h0000;
	logic rd_d = 1'b0;
	logic busy = 1'b0;
	logic op_erase = 1'b0;
	logic [14:0] op_addr = 15'h0000;
	logic [223:0] op_row;
	logic [14:0] wa;
	function automatic fspc_word_t peek(input logic [14:0] x);
		return mem.exists(x) ? mem[x] : 14'h3FFF;
	endfunction
	////////////////////////////////////////
	// Read data is valid for one cycle only; outside it the line shows the inverse.
	assign fl_rdata = rd_d ? last_q : ~last_q;
	always @(posedge pclk) begin
		rd_d <= fl_req.rd;
		if (fl_req.rd) begin
			last_q <= peek(fl_req.addr);
		end
		if (fl_req.erase || fl_req.prog) begin
			busy <= 1'b1;
			op_erase <= fl_req.erase;
			op_addr <= fl_req.addr;
			op_row <= fl_row_data;
		end else if (busy) begin
			busy <= 1'b0;
			// Commit at the end of the pulse; programming can only clear bits.
			for (int i = 0; i < 16; i++) begin
				wa = {op_addr[14:4], i[3:0]};
				mem[wa] = op_erase ? 14'h3FFF : peek(wa) & op_row[i*14 +: 14];
			end
		end
	end
endmodule

// file: test/tb_top.sv
`timescale 1ns/100ps
module tb_top import fspc_pkg::*; ;
	localparam int PC = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_n = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic cfg_code_protect_n = 1'b1;
	logic [1:0] cfg_write_protect = 2'b11;
	logic ext_rd_req = 1'b0;
	logic ext_wr_req = 1'b0;
	logic ext_bulk_req = 1'b0;
	logic ext_rd_ok, ext_wr_ok, ext_bulk, cpu_stall, cpu_ignore;
	fspc_flreq_s fl_req;
	logic [223:0] fl_row_data;
	logic [13:0] fl_rdata;
	logic [32:0] exp_q[$];
	int fail_count = 0;
	int checks_done = 0;
	logic [14:0] a;
	logic [13:0] d, d2;
	logic [31:0] r;

	fspc_top #(.PROG_CYC(PC)) i_dut (.pclk, .presetn, .por_n, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cfg_code_protect_n, .cfg_write_protect, .ext_rd_req,
		.ext_wr_req, .ext_bulk_req, .ext_rd_ok, .ext_wr_ok, .ext_bulk, .fl_req, .fl_row_data, .fl_rdata,
		.cpu_stall, .cpu_ignore);
	fspc_flash_model i_flash (.pclk, .fl_req, .fl_row_data, .fl_rdata);

	always #5 pclk = ~pclk;

	////////////////////////////////////////
	task chk(input logic [223:0] seen, input logic [223:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task test_done;
		if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Read results are compared where the bus samples them, oldest note first.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
	end

	// The idle cycle after each transfer keeps psel from being driven twice in one step.
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		apb_go(w, ad, wd);
		@(posedge pclk);
	endtask

	// Returns at the edge that completes the access, so the caller may look at the very next cycle.
	task apb_go(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50) fail_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [7:0] ad, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, ad, 32'h0000_0000);
	endtask

	task fstart(input logic [14:0] fa, input logic [13:0] fd, input logic [7:0] c, input logic [7:0] k);
		apb(1'b1, 8'h00, {24'h00_0000, fa[7:0]});
		apb(1'b1, 8'h04, {25'h000_0000, fa[14:8]});
		apb(1'b1, 8'h08, {24'h00_0000, fd[7:0]});
		apb(1'b1, 8'h0C, {26'h000_0000, fd[13:8]});
		apb(1'b1, 8'h10, {24'h00_0000, c & 8'hFD});
		apb(1'b1, 8'h14, 32'h0000_0055);
		apb(1'b1, 8'h14, {24'h00_0000, k});
		apb(1'b1, 8'h10, {24'h00_0000, c});
	endtask

	task fop(input logic [14:0] fa, input logic [13:0] fd, input logic [7:0] c, input logic [7:0] k, input int en);
		int n;
		logic [223:0] er;
		fstart(fa, fd, c, k);
		#1 n = 0;
		while (cpu_stall === 1'b1 && n < 1000) begin
			@(posedge pclk);
			#1 n++;
			if (n == 1 && !c[4]) chk(fl_row_data[fa[3:0]*14 +: 14], fd);
		end
		chk(n, en);
		// A load-only start keeps its word in the latches; a finished program leaves all ones.
		er = {16{14'h3FFF}};
		if (c[5]) er[fa[3:0]*14 +: 14] = fd;
		chk(fl_row_data, er);
		@(posedge pclk);
		rd(8'h10, {25'h000_0000, c & 8'hFD});
	endtask

	task fread(input logic [14:0] fa, input logic [13:0] e);
		apb(1'b1, 8'h00, {24'h00_0000, fa[7:0]});
		apb(1'b1, 8'h04, {25'h000_0000, fa[14:8]});
		apb_go(1'b1, 8'h10, 32'h0000_0001);
		#1 chk({fl_req.rd, cpu_ignore, fl_req.config_space_select, fl_req.addr}, {3'b110, fa});
		@(posedge pclk);
		repeat (2) @(posedge pclk);
		rd(8'h08, {25'h000_0000, e[7:0]});
		rd(8'h0C, {27'h000_0000, e[13:8]});
		rd(8'h10, 33'h0_0000_0000);
	endtask

	////////////////////////////////////////
	initial begin
		void'($urandom(32'h1553_2877));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge pclk);
		rd(8'h10, 33'h0_0000_0000);
		apb(1'b1, 8'h14, 32'h0000_0055);
		rd(8'h14, 33'h0_0000_0000);
		rd(8'h1C, 33'h1_0000_0000);
		rd(8'h18, 33'h0_0000_0007);
		apb(1'b1, 8'h04, 32'h0000_00FF);
		rd(8'h04, 33'h0_0000_007F);
		apb(1'b1, 8'h0C, 32'h0000_00FF);
		rd(8'h0C, 33'h0_0000_003F);
		// A write while the clock enable is low must be lost.
		ce <= 1'b0;
		apb(1'b1, 8'h04, 32'h0000_0001);
		ce <= 1'b1;
		rd(8'h04, 33'h0_0000_007F);
		a = 15'($urandom);
		d = 14'($urandom);
		d2 = 14'($urandom);
		fop(a, d, 8'h06, 8'hAA, PC + 1);
		fread(a, d);
		fop(a ^ 15'h0001, d2, 8'h06, 8'hAA, PC + 1);
		fread(a ^ 15'h0001, d2);
		fread(a, d);
		fop(a, 14'h0000, 8'h06, 8'h12, 0);
		fop(a, 14'h0000, 8'h02, 8'hAA, 0);
		cfg_write_protect <= 2'b00;
		fop(a, 14'h0000, 8'h16, 8'hAA, 0);
		cfg_write_protect <= 2'b11;
		fop(a, 14'h0000, 8'h16, 8'hAA, PC + 1);
		fread(a, 14'h3FFF);
		fread(a ^ 15'h0001, 14'h3FFF);
		fop(a, d, 8'h06, 8'hAA, PC + 1);
		fread(a, d);
		cfg_write_protect <= 2'b00;
		fop(a ^ 15'h0002, d2, 8'h66, 8'hAA, 1);
		cfg_write_protect <= 2'b11;
		fop(a ^ 15'h0003, d, 8'h06, 8'hAA, PC + 1);
		fread(a ^ 15'h0002, d2);
		fread(a ^ 15'h0003, d);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			{cfg_code_protect_n, ext_rd_req, ext_wr_req, ext_bulk_req} <= r[3:0];
			@(posedge pclk);
			#1 chk({ext_rd_ok, ext_wr_ok, ext_bulk}, {r[3] & r[2], r[3] & r[1], r[0]});
			@(posedge pclk);
		end
		cfg_code_protect_n <= 1'b1;
		fstart(a, d, 8'h06, 8'hAA);
		apb(1'b1, 8'h10, 32'h0000_0004);
		rd(8'h10, 33'h0_0000_0006);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h10, 33'h0_0000_0008);
		apb(1'b1, 8'h10, 32'h0000_0000);
		rd(8'h10, 33'h0_0000_0000);
		repeat (2) @(posedge pclk);
		chk(exp_q.size(), 0);
		test_done();
	end

	// The whole sequence needs well under 20 us.
	initial begin
		#200us;
		fail_count++;
		test_done();
	end
endmodule
